//--- src/adc_pkg.sv
// shared constants and types of the converter control block
// assumes an 8-bit bus with 16-bit addresses and one system clock
package adc_pkg;
    localparam logic [15:0] ADDR_RESULT_BASE = 16'hFF90;
    localparam logic [15:0] ADDR_CTRL_STATUS = 16'hFF98;
    localparam logic [15:0] ADDR_TRIG_CTRL   = 16'hFF99;
    localparam logic [15:0] ADDR_STOP_HI     = 16'hFF3C;
    localparam logic [15:0] ADDR_STOP_LO     = 16'hFF3D;
    localparam int RES_IDX_HI = 2;
    localparam int RES_IDX_LO = 1;
    localparam int RES_DEC_LO = 3;

    localparam int DONE_BIT  = 7;
    localparam int IRQEN_BIT = 6;
    localparam int RUN_BIT   = 5;
    localparam int SCAN_BIT  = 4;
    localparam int SPEED_BIT = 3;
    localparam int GROUP_BIT = 2;
    localparam int MODE_W    = 5;
    localparam int TRIG_HI   = 7;
    localparam int TRIG_LO   = 6;
    localparam int STOP_BIT  = 9;

    localparam logic [7:0]  CSR_RESET    = 8'h00;
    localparam logic [1:0]  TRIG_RESET   = 2'h0;
    localparam logic [5:0]  TRIG_RSVD    = 6'h3F;
    localparam logic [15:0] STOP_RESET   = 16'h3FFF;
    localparam logic [5:0]  RESULT_PAD   = 6'h00;
    localparam logic [7:0]  READ_NONE    = 8'h00;

    localparam int CONV_FIRST_SLOW = 266;
    localparam int CONV_FIRST_FAST = 134;
    localparam int CONV_NEXT_SLOW  = 256;
    localparam int CONV_NEXT_FAST  = 128;
    localparam int CNT_W           = 9;
    localparam int RESULT_W        = 10;
    localparam int CHANNELS        = 4;

    typedef enum logic [1:0] {
        TRIG_NONE, TRIG_PULSE_TIMER, TRIG_TIMER8, TRIG_PIN
    } trig_src_e;

    typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic        xfer_ctrl;
        logic [7:0]  wdata;
    } bus_req_s;
endpackage

//--- src/adc_control_and_readout.sv
// converter control, trigger, unit-stop and result readout logic
// assumes one bus cycle per clock, a synchronous analog core result
// on sample_in, and inputs already synchronous to clk_in
//
// What this block does
// - done flag: single end, or whole scan group
// - write 0 after reading 1 clears done
// - transfer controller result read clears done
// - end interrupt only while enable bit set
// - run set by software, timer, or pin
// - single mode clears run at completion
// - scan repeats until cleared, standby, stop
// - scan bit selects single or scan mode
// - speed bit: 266 or 134 states max
// - single mode converts channel field input
// - scan group bit, count is low+1
// - control/status zero on reset, standby, stop
// - trigger code picks none, pulse, timer8, pin
// - trigger low six bits read one
// - trigger register 0x3F on reset, standby, stop
// - stop bit halts converter, clear resumes
// - unit-stop blocks converter register access
// - stop register 0x3FFF; survives software standby
// - upper byte read latches lower byte
// - lower byte read returns latched byte
// - result left aligned, bits 5..0 zero
// - inputs n and n+4 share result n
// - pin falling edge starts like software
module adc_control_and_readout
#(
    parameter int FIRST_SLOW = adc_pkg::CONV_FIRST_SLOW,
    parameter int FIRST_FAST = adc_pkg::CONV_FIRST_FAST,
    parameter int NEXT_SLOW  = adc_pkg::CONV_NEXT_SLOW,
    parameter int NEXT_FAST  = adc_pkg::CONV_NEXT_FAST
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      hw_standby_in,
    input  wire logic                      sw_standby_in,
    input  wire adc_pkg::bus_req_s         bus_in,
    input  wire logic                      ext_trigger_pin_in,
    input  wire logic                      pulse_timer_trig_in,
    input  wire logic                      timer8_trig_in,
    input  wire logic [adc_pkg::RESULT_W-1:0] sample_in,
    output logic [7:0]                     rdata_out,
    output logic                           conversion_end_irq_out,
    output logic [2:0]                     sample_channel_out,
    output logic                           converting_out
);
    import adc_pkg::*;

    function automatic logic [CNT_W-1:0] conv_reload(input logic fast,
                                                     input logic first);
        int n;
        n = first ? (fast ? FIRST_FAST : FIRST_SLOW)
                  : (fast ? NEXT_FAST : NEXT_SLOW);
        return CNT_W'(n - 1);
    endfunction

    logic [7:0]           csr_q;
    logic [7:0]           csr_d;
    logic [1:0]           trig_q;
    logic [1:0]           trig_d;
    logic [15:0]          stop_q;
    logic [15:0]          stop_d;
    logic [7:0]           temp_q;
    logic [7:0]           rdata_d;
    logic                 seen_q;
    logic                 seen_d;
    logic                 pin_prev_q;
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic [2:0]           chan_q;
    logic [2:0]           chan_d;
    conv_state_e          state_q;
    conv_state_e          state_d;
    logic [RESULT_W-1:0]  result_q [CHANNELS];

    // address decode
    wire sel_csr    = bus_in.addr == ADDR_CTRL_STATUS;
    wire sel_trig   = bus_in.addr == ADDR_TRIG_CTRL;
    wire sel_res    = bus_in.addr[15:RES_DEC_LO]
                      == ADDR_RESULT_BASE[15:RES_DEC_LO];
    wire sel_st_hi  = bus_in.addr == ADDR_STOP_HI;
    wire sel_st_lo  = bus_in.addr == ADDR_STOP_LO;
    wire [1:0] ridx = bus_in.addr[RES_IDX_HI:RES_IDX_LO];
    wire res_hi     = !bus_in.addr[0];

    // unit-stop and standby force the converter into its reset state
    wire stop_bit = stop_q[STOP_BIT];
    wire srst     = stop_bit | hw_standby_in | sw_standby_in;
    wire acc_ok   = !stop_bit;

    wire wr_csr   = bus_in.wr & sel_csr & acc_ok;
    wire rd_csr   = bus_in.rd & sel_csr & acc_ok;
    wire wr_trig  = bus_in.wr & sel_trig & acc_ok;
    wire rd_res   = bus_in.rd & sel_res & acc_ok;
    wire rd_res_h = rd_res & res_hi;
    wire dtc_rd   = rd_res & bus_in.xfer_ctrl;

    // fields as seen this cycle, including a same-cycle write
    wire [MODE_W-1:0] mode_n = wr_csr ? bus_in.wdata[MODE_W-1:0]
                                      : csr_q[MODE_W-1:0];
    wire scan_n   = mode_n[SCAN_BIT];
    wire speed_n  = mode_n[SPEED_BIT];
    wire ie_n     = wr_csr ? bus_in.wdata[IRQEN_BIT] : csr_q[IRQEN_BIT];
    wire scan_q   = csr_q[SCAN_BIT];
    wire run_q    = csr_q[RUN_BIT];
    wire done_q   = csr_q[DONE_BIT];

    // start triggers
    wire trig_src_e trig_sel = trig_src_e'(trig_q);
    wire pin_fall = pin_prev_q & !ext_trigger_pin_in;
    wire trig_fire =
        (trig_sel == TRIG_PULSE_TIMER && pulse_timer_trig_in) ||
        (trig_sel == TRIG_TIMER8 && timer8_trig_in) ||
        (trig_sel == TRIG_PIN && pin_fall);

    // conversion sequencing
    wire done_evt = state_q == ST_CONVERT && cnt_q == '0;
    wire last_ch  = chan_q[1:0] == csr_q[1:0];
    wire done_set = done_evt & (!scan_q | last_ch);

    wire run_d = srst                  ? 1'b0 :
                 wr_csr                ? bus_in.wdata[RUN_BIT] :
                 trig_fire             ? 1'b1 :
                 (done_evt & !scan_q)  ? 1'b0 : run_q;

    wire start_evt = state_q == ST_IDLE && run_d;
    assign state_d = run_d ? ST_CONVERT : ST_IDLE;

    // the first conversion includes start delay and sampling
    assign cnt_d = start_evt ? conv_reload(speed_n, 1'b1) :
                   done_evt  ? conv_reload(speed_n, 1'b0) :
                   (state_q == ST_CONVERT) ? cnt_q - 1'b1 : cnt_q;

    assign chan_d =
        start_evt ? (scan_n ? {mode_n[GROUP_BIT], 2'b00}
                            : mode_n[2:0]) :
        (done_evt & scan_q) ? (last_ch ? {chan_q[2], 2'b00}
                                       : chan_q + 3'h1) : chan_q;

    // done flag: a set in the same cycle as a clear wins
    wire done_clr = (wr_csr & !bus_in.wdata[DONE_BIT] & seen_q)
                    | dtc_rd;
    wire done_d = srst     ? 1'b0 :
                  done_set ? 1'b1 :
                  done_clr ? 1'b0 : done_q;
    assign seen_d = srst ? 1'b0 :
                    (rd_csr & done_q) ? 1'b1 :
                    (done_clr & !done_set) ? 1'b0 : seen_q;

    assign csr_d = srst ? CSR_RESET
                        : {done_d, ie_n, run_d, mode_n};
    assign trig_d = srst ? TRIG_RESET :
                    wr_trig ? bus_in.wdata[TRIG_HI:TRIG_LO] : trig_q;

    // unit-stop register lives outside the converter reset domain
    assign stop_d =
        hw_standby_in ? STOP_RESET :
        (bus_in.wr & sel_st_hi) ? {bus_in.wdata, stop_q[7:0]} :
        (bus_in.wr & sel_st_lo) ? {stop_q[15:8], bus_in.wdata} : stop_q;

    // read mux; blocked registers read as zero in unit-stop
    wire [7:0] res_upper = result_q[ridx][RESULT_W-1:2];
    wire [7:0] res_lower = {result_q[ridx][1:0], RESULT_PAD};
    assign rdata_d =
        sel_st_hi ? stop_q[15:8] :
        sel_st_lo ? stop_q[7:0] :
        !acc_ok   ? READ_NONE :
        sel_csr   ? csr_q :
        sel_trig  ? {trig_q, TRIG_RSVD} :
        sel_res   ? (res_hi ? res_upper : temp_q) :
        READ_NONE;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            csr_q  <= CSR_RESET;
            trig_q <= TRIG_RESET;
            stop_q <= STOP_RESET;
            seen_q <= 1'b0;
        end else begin
            csr_q  <= csr_d;
            trig_q <= trig_d;
            stop_q <= stop_d;
            seen_q <= seen_d;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            chan_q     <= '0;
            pin_prev_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            chan_q     <= chan_d;
            pin_prev_q <= ext_trigger_pin_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_q <= '{default: '0};
        end else if (srst) begin
            result_q <= '{default: '0};
        end else if (done_evt) begin
            result_q[chan_q[1:0]] <= sample_in;
        end
    end

    // the lower byte is only coherent if the upper byte went first
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            temp_q <= READ_NONE;
        end else if (srst) begin
            temp_q <= READ_NONE;
        end else if (rd_res_h) begin
            temp_q <= res_lower;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out              <= READ_NONE;
            conversion_end_irq_out <= 1'b0;
            sample_channel_out     <= '0;
            converting_out         <= 1'b0;
        end else begin
            if (bus_in.rd) begin
                rdata_out <= rdata_d;
            end
            conversion_end_irq_out <= done_d & ie_n;
            sample_channel_out     <= chan_d;
            converting_out         <= state_d == ST_CONVERT;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_upper_read(logic [1:0] i);
        rd_res_h && ridx == i;
    endsequence
    sequence s_lower_read(logic [1:0] i);
        rd_res && !res_hi && ridx == i && !bus_in.xfer_ctrl;
    endsequence

    a_single_done_sets: assert property (
        done_evt && !scan_q && !srst |=> done_q)
        else $error("single end did not set done");

    a_scan_mid_quiet: assert property (
        done_evt && scan_q && !last_ch && !done_q && !srst
        && !(wr_csr && bus_in.wdata[DONE_BIT]) |=> !done_q)
        else $error("done set before scan group end");

    a_clear_after_read: assert property (
        rd_csr && done_q && !srst ##2 (wr_csr && !bus_in.wdata[DONE_BIT]
        && !done_set && !srst) |=> !done_q)
        else $error("done not cleared after read then write 0");

    a_no_clear_unread: assert property (
        done_q && !seen_q && wr_csr && !dtc_rd && !srst |=> done_q)
        else $error("done cleared without prior read");

    a_xfer_clears: assert property (
        dtc_rd && !done_set && !srst |=> !done_q)
        else $error("transfer read did not clear done");

    a_irq_gate: assert property (
        conversion_end_irq_out == (done_q && csr_q[IRQEN_BIT]))
        else $error("interrupt not equal to done and enable");

    a_single_run_end: assert property (
        done_evt && !scan_q && !wr_csr && !trig_fire
        |=> !run_q && state_q == ST_IDLE)
        else $error("single mode run bit not cleared");

    a_stop_kills_run: assert property (
        srst |=> !run_q && state_q == ST_IDLE)
        else $error("run survived standby or stop");

    a_pin_start: assert property (
        trig_sel == TRIG_PIN && pin_fall && !srst && !wr_csr
        |=> run_q ##0 state_q == ST_CONVERT)
        else $error("pin falling edge did not start");

    a_fast_length: assert property (
        start_evt && speed_n && !srst
        |-> ##FIRST_FAST (done_evt || !run_q || srst || !$past(run_q)))
        else $error("fast conversion time wrong");

    a_slow_length: assert property (
        start_evt && !speed_n && !srst
        |-> ##FIRST_SLOW (done_evt || !run_q || srst || !$past(run_q)))
        else $error("slow conversion time wrong");

    a_trig_rsvd_ones: assert property (
        bus_in.rd && sel_trig && acc_ok |=> rdata_out[5:0] == TRIG_RSVD)
        else $error("trigger reserved bits not one");

    a_stop_blocks: assert property (
        stop_bit && bus_in.rd && (sel_csr || sel_res)
        |=> rdata_out == READ_NONE)
        else $error("register readable in unit-stop");

    a_lower_latched: assert property (
        s_upper_read(2'h0) ##0 !srst ##1 (!rd_res_h && !srst) ##1
        s_lower_read(2'h0)
        |=> rdata_out == {$past(result_q[0][1:0], 3), RESULT_PAD})
        else $error("lower byte not taken from latch");

    a_standby_keeps_stop: assert property (
        sw_standby_in && !hw_standby_in && !bus_in.wr
        |=> stop_q == $past(stop_q))
        else $error("stop register lost in software standby");

    a_trig_none_idle: assert property (
        trig_sel == TRIG_NONE && state_q == ST_IDLE && !wr_csr
        |=> state_q == ST_IDLE)
        else $error("start taken with triggers disabled");

    a_write_one_noop: assert property (
        wr_csr && bus_in.wdata[DONE_BIT] && !done_q && !done_set
        |=> !done_q)
        else $error("writing one set the done flag");

    a_csr_cleared: assert property (
        srst |=> csr_q == CSR_RESET)
        else $error("control/status not cleared");

    a_trig_cleared: assert property (
        srst |=> trig_q == TRIG_RESET)
        else $error("trigger select not cleared");

    a_hw_stop_init: assert property (
        hw_standby_in |=> stop_q == STOP_RESET)
        else $error("stop register not set by hardware standby");

    a_upper_direct: assert property (
        s_upper_read(2'h1)
        |=> rdata_out == $past(result_q[1][RESULT_W-1:2]))
        else $error("upper byte read wrong");

    a_irq_masked: assert property (
        !csr_q[IRQEN_BIT] |-> !conversion_end_irq_out)
        else $error("interrupt raised while disabled");
endmodule

//--- verif/adc_far_side.sv
// far-side model: analog core levels and the three start sources
// assumes the bench sets level[] and calls fire() between edges
module adc_far_side
(
    input  wire logic                     clk_in,
    input  wire logic [2:0]               channel_in,
    output logic [adc_pkg::RESULT_W-1:0]  sample_out,
    output logic                          pulse_out,
    output logic                          timer8_out,
    output logic                          pin_out
);
    import adc_pkg::*;

    logic [RESULT_W-1:0] level [8];

    assign sample_out = level[channel_in];

    initial begin
        pulse_out  = 1'b0;
        timer8_out = 1'b0;
        pin_out    = 1'b1;
    end

    // one source per call; the pin idles high and starts on its fall
    task automatic fire(input int src);
        @(negedge clk_in);
        pulse_out  = (src == 1);
        timer8_out = (src == 2);
        pin_out    = (src != 3);
        @(negedge clk_in);
        pulse_out  = 1'b0;
        timer8_out = 1'b0;
        pin_out    = 1'b1;
    endtask
endmodule

//--- verif/test_adc_control_and_readout.sv
// self-checking bench of the converter control block
// assumes the far-side model and shortened conversion counts
module test_adc_control_and_readout;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_pkg::*;

    localparam int FSL = 10;
    localparam int FFA = 6;
    localparam int NSL = 8;
    localparam int NFA = 4;
    logic                clk_in = 1'b0;
    logic                rst_in = 1'b1;
    logic                hw_sb  = 1'b0;
    logic                sw_sb  = 1'b0;
    bus_req_s            bus    = '0;
    logic [RESULT_W-1:0] sample;
    logic                pt, t8, pin, irq, conv;
    logic [7:0]          rdata, got, w;
    logic [2:0]          chan;
    logic [15:0]         res [4];
    int                  failures    = 0;
    int                  check_count = 0;
    int                  seed        = 32'h9b22;
    int                  n;

    always #2.5 clk_in = ~clk_in;

    adc_control_and_readout #(
        .FIRST_SLOW (FSL),
        .FIRST_FAST (FFA),
        .NEXT_SLOW  (NSL),
        .NEXT_FAST  (NFA)
    ) i_dut (
        .clk_in                 (clk_in),
        .rst_in                 (rst_in),
        .hw_standby_in          (hw_sb),
        .sw_standby_in          (sw_sb),
        .bus_in                 (bus),
        .ext_trigger_pin_in     (pin),
        .pulse_timer_trig_in    (pt),
        .timer8_trig_in         (t8),
        .sample_in              (sample),
        .rdata_out              (rdata),
        .conversion_end_irq_out (irq),
        .sample_channel_out     (chan),
        .converting_out         (conv)
    );

    adc_far_side i_far (
        .clk_in     (clk_in),
        .channel_in (chan),
        .sample_out (sample),
        .pulse_out  (pt),
        .timer8_out (t8),
        .pin_out    (pin)
    );

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        chk8({7'h0, v >= lo && v <= hi}, 8'h01);
    endtask

    // one access; read data is taken one cycle after the strobe
    task automatic acc(input logic [15:0] a, input logic wr,
                       input logic [7:0] d, input logic x = 1'b0);
        @(negedge clk_in);
        bus = '{addr: a, rd: !wr, wr: wr, xfer_ctrl: x, wdata: d};
        @(negedge clk_in);
        bus.rd = 1'b0;
        bus.wr = 1'b0;
        got = rdata;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        acc(a, 1'b0, 8'h00);
        chk8(got, e);
    endtask

    // bounded wait; running out ends the run as a failure
    task automatic wait_sig(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 400) begin
            @(negedge clk_in);
            c++;
        end
        if (c >= 400) begin
            failures++;
            conclude();
        end
    endtask

    initial begin
        for (int i = 0; i < 8; i++)
            i_far.level[i] = RESULT_W'($random(seed));
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        rdc(ADDR_STOP_HI, 8'h3F);
        rdc(ADDR_STOP_LO, 8'hFF);
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h20);
        chk8({7'h0, conv}, 8'h00);
        rdc(ADDR_CTRL_STATUS, 8'h00);
        acc(ADDR_STOP_HI, 1'b1, 8'h3D);
        rdc(ADDR_STOP_HI, 8'h3D);
        rdc(ADDR_CTRL_STATUS, 8'h00);
        rdc(ADDR_TRIG_CTRL, 8'h3F);
        rdc(16'hFF40, 8'h00);
        for (int c = 0; c < 4; c++) begin
            acc(ADDR_TRIG_CTRL, 1'b1, {c[1:0], 6'h00});
            rdc(ADDR_TRIG_CTRL, {c[1:0], 6'h3F});
            for (int s = 1; s < 4; s++) begin
                i_far.fire(s);
                chk8({7'h0, conv}, {7'h0, c == s});
                wait_sig(conv, 1'b0, n);
            end
        end
        acc(ADDR_TRIG_CTRL, 1'b1, 8'h00);
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h00);
        rdc(ADDR_CTRL_STATUS, 8'h80);
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h00);
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h80);
        rdc(ADDR_CTRL_STATUS, 8'h00);
        for (int k = 0; k < 4; k++) begin
            w = {1'b0, k[1], 1'b1, 1'b0, k[0], 3'($random(seed))};
            acc(ADDR_CTRL_STATUS, 1'b1, w);
            chk8({5'h0, chan}, {5'h0, w[2:0]});
            wait_sig(conv, 1'b0, n);
            rng(n, (k[0] ? FFA : FSL) - 1, (k[0] ? FFA : FSL) + 1);
            @(negedge clk_in);
            chk8({7'h0, irq}, {7'h0, k[1]});
            rdc(ADDR_CTRL_STATUS, {1'b1, w[6], 1'b0, w[4:0]});
            res[w[1:0]] = {i_far.level[w[2:0]], 6'h00};
            rdc({ADDR_RESULT_BASE[15:3], w[1:0], 1'b0},
                res[w[1:0]][15:8]);
            rdc({ADDR_RESULT_BASE[15:3], w[1:0], 1'b1},
                res[w[1:0]][7:0]);
            acc(ADDR_CTRL_STATUS, 1'b1, 8'h00);
            @(negedge clk_in);
            chk8({7'h0, irq}, 8'h00);
        end
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h76);
        chk8({5'h0, chan}, 8'h04);
        wait_sig(irq, 1'b1, n);
        rng(n, FSL + 2 * NSL - 1, FSL + 2 * NSL + 2);
        chk8({7'h0, conv}, 8'h01);
        for (int j = 0; j < 3; j++)
            rdc({ADDR_RESULT_BASE[15:3], j[1:0], 1'b0},
                i_far.level[4 + j][9:2]);
        rdc(ADDR_RESULT_BASE, i_far.level[4][9:2]);
        rdc(ADDR_RESULT_BASE | 16'h0001,
            {i_far.level[4][1:0], 6'h00});
        acc(ADDR_RESULT_BASE, 1'b0, 8'h00, 1'b1);
        repeat (2) @(negedge clk_in);
        chk8({7'h0, irq}, 8'h00);
        sw_sb = 1'b1;
        @(negedge clk_in);
        sw_sb = 1'b0;
        chk8({7'h0, conv}, 8'h00);
        rdc(ADDR_CTRL_STATUS, 8'h00);
        rdc(ADDR_STOP_HI, 8'h3D);
        acc(ADDR_CTRL_STATUS, 1'b1, 8'h20);
        acc(ADDR_STOP_HI, 1'b1, 8'h3F);
        @(negedge clk_in);
        chk8({7'h0, conv}, 8'h00);
        rdc(ADDR_CTRL_STATUS, 8'h00);
        acc(ADDR_STOP_LO, 1'b1, 8'h00);
        hw_sb = 1'b1;
        @(negedge clk_in);
        hw_sb = 1'b0;
        rdc(ADDR_STOP_LO, 8'hFF);
        conclude();
    end
endmodule
